/* File: core/epan_defs.svh */
// Offsets, field positions, reset values and counts for the emulated partner logic
`ifndef EPAN_DEFS_SVH
`define EPAN_DEFS_SVH
`define EPAN_P1_EXP_OFFS 9'h0D8
`define EPAN_P0_EXP_OFFS 9'h1D8
`define EPAN_EXP_INDEX 5'h06
`define EPAN_EXP_PDF_BIT 4
`define EPAN_EXP_LPNP_BIT 3
`define EPAN_EXP_LNP_BIT 2
`define EPAN_EXP_PR_BIT 1
`define EPAN_EXP_LPAN_BIT 0
`define EPAN_ADV_ASYM_BIT 11
`define EPAN_ADV_SYM_BIT 10
`define EPAN_ACK_BIT 14
`define EPAN_SELECTOR 5'h01
`define EPAN_ABIL_10FD 4'h2
`define EPAN_ABIL_100FD 4'h8
`define EPAN_ABIL_10HD 4'h1
`define EPAN_ABIL_100HD 4'h4
`define EPAN_PR_RST 1'h0
`define EPAN_LPAN_RST 1'h1
`define EPAN_LP_RST 16'h0000
`define EPAN_SETTLE_CYC 2'h3
`endif

/* File: core/epan_pkg.sv */
// Types shared by the emulated partner logic
package epan_pkg;
	typedef enum logic [1:0] {
		EPAN_ST_SETTLE = 2'b00,
		EPAN_ST_NEG = 2'b01,
		EPAN_ST_DONE = 2'b10
	} epan_state_t;
endpackage : epan_pkg

/* File: core/epan_top.sv */
// Emulated link partner and expansion register for both switch ports
`timescale 1ns/1ps
`include "epan_defs.svh"
`default_nettype none

module epan_port (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [15:0] loc_abil_in,
	input wire logic duplex_in,
	input wire logic speed_in,
	input wire logic resolve_in,
	input wire logic an_restart_in,
	input wire logic rd_clr_in,
	output logic [15:0] exp_out,
	output logic [15:0] lp_abil_out
);
	import epan_pkg::*;

	function automatic logic [1:0] pause_map(input logic sym, input logic asym, input logic res);
		logic [1:0] r;
		r = 2'h0;
		case ({sym, asym})
			2'b10: r = 2'b01;
			2'b01: r = 2'b11;
			2'b11: r = res ? 2'b11 : 2'b10;
			default: r = 2'b00;
		endcase
		return r;
	endfunction : pause_map

	function automatic logic [3:0] speed_map(input logic dup, input logic spd);
		logic [3:0] r;
		r = 4'h0;
		case ({dup, spd})
			2'b10: r = `EPAN_ABIL_10FD;
			2'b11: r = `EPAN_ABIL_100FD;
			2'b00: r = `EPAN_ABIL_10HD;
			default: r = `EPAN_ABIL_100HD;
		endcase
		return r;
	endfunction : speed_map

	epan_state_t st_q, st_d;
	logic [1:0] cnt_q;
	logic pr_q;
	logic lpan_q;
	logic [1:0] pause_q;
	logic [3:0] spd_q;

	wire logic sym_w = loc_abil_in[`EPAN_ADV_SYM_BIT];
	wire logic asym_w = loc_abil_in[`EPAN_ADV_ASYM_BIT];
	wire logic [1:0] pause_w = pause_map(sym_w, asym_w, resolve_in);
	wire logic [3:0] strap_abil_w = speed_map(duplex_in, speed_in);
	wire logic common_w = |(loc_abil_in[8:5] & strap_abil_w);
	wire logic neg_w = (st_q == EPAN_ST_NEG);

	always_comb begin
		st_d = st_q;
		case (st_q)
			EPAN_ST_SETTLE: st_d = (cnt_q == `EPAN_SETTLE_CYC) ? EPAN_ST_NEG : EPAN_ST_SETTLE;
			EPAN_ST_NEG: st_d = EPAN_ST_DONE;
			EPAN_ST_DONE: st_d = an_restart_in ? EPAN_ST_NEG : EPAN_ST_DONE;
			default: st_d = EPAN_ST_SETTLE;
		endcase
	end

	// Settling lets the strap synchronisers fill before the first negotiation
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= EPAN_ST_SETTLE;
			cnt_q <= 2'h0;
		end else if (ce_in) begin
			st_q <= st_d;
			cnt_q <= (st_q == EPAN_ST_SETTLE) ? cnt_q + 2'h1 : 2'h0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pr_q <= `EPAN_PR_RST;
			lpan_q <= `EPAN_LPAN_RST;
			pause_q <= 2'h0;
			spd_q <= 4'h0;
		end else if (ce_in) begin
			// Set wins over a read in the same cycle so a new page is never lost
			if (neg_w) begin
				pr_q <= 1'b1;
			end else if (rd_clr_in) begin
				pr_q <= 1'b0;
			end
			if (neg_w) begin
				lpan_q <= common_w;
				pause_q <= pause_w;
				spd_q <= common_w ? strap_abil_w : 4'h0;
			end
		end
	end

	assign exp_out = {11'h000, 3'h0, pr_q, lpan_q};
	assign lp_abil_out = {1'b0, 1'b1, 2'h0, pause_q, 1'b0, spd_q, `EPAN_SELECTOR};

	AST_PAUSE_NONE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(neg_w && ce_in && !sym_w && !asym_w) |=> (lp_abil_out[11:10] == 2'b00))
		else $error("partner pause not clear");
	AST_PAUSE_ASYM: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(neg_w && ce_in && !sym_w && asym_w) |=> (lp_abil_out[11:10] == 2'b11))
		else $error("asymmetric only must give both partner pause bits");
	AST_PAUSE_RESOLVE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(neg_w && ce_in && sym_w && asym_w) |=>
		(lp_abil_out[11:10] == ($past(resolve_in) ? 2'b11 : 2'b10)))
		else $error("pause resolve strap ignored");
	AST_SPEED_10FD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(neg_w && ce_in && duplex_in && !speed_in && loc_abil_in[6]) |=>
		(lp_abil_out[8:5] == 4'b0010))
		else $error("10 full strap mapping wrong");
	AST_FAIL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(neg_w && ce_in && !common_w) |=> (lp_abil_out[8:5] == 4'h0) && !exp_out[0])
		else $error("failed negotiation not reflected");
	AST_FIXED_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		exp_out[15:2] == 14'h0000)
		else $error("fixed expansion bits not zero");
	AST_RD_CLR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(rd_clr_in && ce_in && !neg_w) |=> !exp_out[1])
		else $error("page received not cleared by read");
	AST_PAGE_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(neg_w && ce_in) |=> (exp_out[1] && (st_q == EPAN_ST_DONE)))
		else $error("page received not set by negotiation");
	AST_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(st_q == EPAN_ST_DONE && !(ce_in && an_restart_in)) |=> $stable(lp_abil_out))
		else $error("partner ability changed without renegotiation");
endmodule : epan_port

module epan_top (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	input wire logic [15:0] LOCAL_ABILITY_P0_IN,
	input wire logic [15:0] LOCAL_ABILITY_P1_IN,
	input wire logic AN_RESTART_P0_IN,
	input wire logic AN_RESTART_P1_IN,
	input wire logic [1:0] DUPLEX_STRAP_IN,
	input wire logic [1:0] SPEED_STRAP_IN,
	input wire logic [1:0] PAUSE_RESOLVE_SELECT_PIN_IN,
	input wire logic [8:0] REG_ADDR_IN,
	input wire logic REG_RD_IN,
	input wire logic REG_WR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	output logic [31:0] REG_RDATA_OUT,
	input wire logic MIIM_RD_IN,
	input wire logic MIIM_PORT_IN,
	input wire logic [4:0] MIIM_INDEX_IN,
	output logic [15:0] MIIM_RDATA_OUT,
	output logic [15:0] LP_ABILITY_P0_OUT,
	output logic [15:0] LP_ABILITY_P1_OUT
);
	import epan_pkg::*;

	logic [5:0] sync1_q, sync2_q;
	logic [31:0] rdata_q;
	logic [15:0] mdata_q;
	logic [15:0] exp0_w, exp1_w;

	// Straps come from pins, so each passes two flip-flops
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
		end else if (CE_IN) begin
			sync1_q <= {PAUSE_RESOLVE_SELECT_PIN_IN, SPEED_STRAP_IN, DUPLEX_STRAP_IN};
			sync2_q <= sync1_q;
		end
	end

	wire logic mm_p0_w = REG_RD_IN && (REG_ADDR_IN == `EPAN_P0_EXP_OFFS);
	wire logic mm_p1_w = REG_RD_IN && (REG_ADDR_IN == `EPAN_P1_EXP_OFFS);
	wire logic mi_exp_w = MIIM_RD_IN && (MIIM_INDEX_IN == `EPAN_EXP_INDEX);
	wire logic clr0_w = mm_p0_w || (mi_exp_w && !MIIM_PORT_IN);
	wire logic clr1_w = mm_p1_w || (mi_exp_w && MIIM_PORT_IN);
	wire logic [15:0] mm_sel_w = mm_p0_w ? exp0_w : (mm_p1_w ? exp1_w : 16'h0000);
	wire logic [15:0] mi_sel_w = mi_exp_w ? (MIIM_PORT_IN ? exp1_w : exp0_w) : 16'h0000;

	epan_port u_port0 (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.ce_in(CE_IN),
		.loc_abil_in(LOCAL_ABILITY_P0_IN),
		.duplex_in(sync2_q[0]),
		.speed_in(sync2_q[2]),
		.resolve_in(sync2_q[4]),
		.an_restart_in(AN_RESTART_P0_IN),
		.rd_clr_in(clr0_w),
		.exp_out(exp0_w),
		.lp_abil_out(LP_ABILITY_P0_OUT)
	);

	epan_port u_port1 (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.ce_in(CE_IN),
		.loc_abil_in(LOCAL_ABILITY_P1_IN),
		.duplex_in(sync2_q[1]),
		.speed_in(sync2_q[3]),
		.resolve_in(sync2_q[5]),
		.an_restart_in(AN_RESTART_P1_IN),
		.rd_clr_in(clr1_w),
		.exp_out(exp1_w),
		.lp_abil_out(LP_ABILITY_P1_OUT)
	);

	// Writes land nowhere: every bit here is read-only
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rdata_q <= 32'h00000000;
			mdata_q <= 16'h0000;
		end else if (CE_IN) begin
			rdata_q <= {16'h0000, mm_sel_w};
			mdata_q <= mi_sel_w;
		end
	end

	assign REG_RDATA_OUT = rdata_q;
	assign MIIM_RDATA_OUT = mdata_q;

	AST_UPPER_ZERO: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		REG_RDATA_OUT[31:16] == 16'h0000)
		else $error("padding bits not zero");
	AST_RD_DATA: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		(CE_IN && mm_p0_w) |=> (REG_RDATA_OUT[15:0] == $past(exp0_w)))
		else $error("port 0 read data wrong");
endmodule : epan_top

`default_nettype wire

/* File: dv/epan_miim_master.sv */
// Management master model that issues single-cycle register reads
`timescale 1ns/1ps
`default_nettype none
module epan_miim_master (
	input wire logic clk_in,
	input wire logic req_in,
	input wire logic port_in,
	input wire logic [4:0] index_in,
	output logic rd_out,
	output logic port_out,
	output logic [4:0] index_out
);
	// Address is not held between reads, so a late sample hits a wrong register
	initial begin
		rd_out = 1'b0;
		port_out = 1'b0;
		index_out = 5'h00;
		forever begin
			@(posedge clk_in);
			rd_out <= req_in;
			port_out <= req_in ? port_in : ~port_out;
			index_out <= req_in ? index_in : ~index_out;
		end
	end
endmodule : epan_miim_master
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the emulated partner block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] loc [2];
	logic [15:0] lp [2];
	logic [15:0] ex [2];
	logic [1:0] an = 2'h0, dup = 2'h0, spd = 2'h0, res = 2'h0;
	logic ce = 1'b1;
	logic [8:0] addr = 9'h000;
	logic reg_rd = 1'b0, reg_wr = 1'b0, m_req = 1'b0, m_port = 1'b0, m_rd, m_pt;
	logic [31:0] wdata = 32'h0, rdata, r;
	logic [4:0] m_idx = 5'h00, m_ix;
	logic [15:0] m_data;
	int err_total = 0, checked = 0, seed = 31, cyc = 0, p;
	epan_top i_epan_top (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
		.LOCAL_ABILITY_P0_IN(loc[0]), .LOCAL_ABILITY_P1_IN(loc[1]),
		.AN_RESTART_P0_IN(an[0]), .AN_RESTART_P1_IN(an[1]), .DUPLEX_STRAP_IN(dup),
		.SPEED_STRAP_IN(spd), .PAUSE_RESOLVE_SELECT_PIN_IN(res), .REG_ADDR_IN(addr),
		.REG_RD_IN(reg_rd), .REG_WR_IN(reg_wr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
		.MIIM_RD_IN(m_rd), .MIIM_PORT_IN(m_pt), .MIIM_INDEX_IN(m_ix), .MIIM_RDATA_OUT(m_data),
		.LP_ABILITY_P0_OUT(lp[0]), .LP_ABILITY_P1_OUT(lp[1]));
	epan_miim_master i_epan_miim_master (.clk_in(clk), .req_in(m_req), .port_in(m_port),
		.index_in(m_idx), .rd_out(m_rd), .port_out(m_pt), .index_out(m_ix));
	initial forever #2 clk = ~clk;
	task automatic end_of_test();
		if (err_total == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Writes ride along with reads at random; all places are read-only
	task automatic rd_reg(input logic [8:0] a, input logic [31:0] exp);
		addr = a;
		reg_rd = 1'b1;
		r = $random(seed);
		reg_wr = r[0];
		wdata = $random(seed);
		@(posedge clk);
		#1 chk(rdata, exp);
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		// Let one edge pass so back-to-back reads never retoggle the strobe in one step
		@(posedge clk);
		#1;
	endtask : rd_reg
	task automatic rd_mii(input logic pt, input logic [4:0] ix, input logic [15:0] exp);
		m_port = pt;
		m_idx = ix;
		m_req = 1'b1;
		@(posedge clk);
		#1 m_req = 1'b0;
		@(posedge clk);
		#1 chk({16'h0000, m_data}, {16'h0000, exp});
	endtask : rd_mii
	function automatic logic [15:0] lp_exp(input logic [15:0] l, input logic d, s, rs);
		logic [3:0] ab;
		logic [1:0] pz;
		ab = d ? (s ? 4'h8 : 4'h2) : (s ? 4'h4 : 4'h1);
		pz = (l[11:10] == 2'h3) ? (rs ? 2'h3 : 2'h2) : (l[11] ? 2'h3 : l[11:10]);
		if ((ab & l[8:5]) == 4'h0) ab = 4'h0;
		return 16'h4001 | {4'h0, pz, 1'b0, ab, 5'h00};
	endfunction : lp_exp
	initial begin
		loc[0] = 16'h0DE1;
		loc[1] = 16'h0DE1;
		repeat (5) @(posedge clk);
		#1 chk(lp[0], 32'h4001);
		rst_n = 1'b1;
		rd_reg(9'h1D8, 32'h1);
		repeat (10) @(posedge clk);
		#1 chk(lp[0], lp_exp(16'h0DE1, 1'b0, 1'b0, 1'b0));
		rd_reg(9'h1D8, 32'h3);
		rd_reg(9'h1D8, 32'h1);
		rd_mii(1'b1, 5'h05, 16'h0000);
		rd_mii(1'b1, 5'h06, 16'h0003);
		rd_reg(9'h1DC, 32'h0);
		ex[0] = lp_exp(16'h0DE1, 1'b0, 1'b0, 1'b0);
		ex[1] = lp_exp(16'h0DE1, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 48; i++) begin
			p = i % 2;
			r = $random(seed);
			{dup, spd, res} = r[5:0];
			loc[p] = r[31:16];
			repeat (3) @(posedge clk);
			#1 an[p] = 1'b1;
			@(posedge clk);
			#1 an[p] = 1'b0;
			repeat (4) @(posedge clk);
			#1 ex[p] = lp_exp(loc[p], dup[p], spd[p], res[p]);
			chk(lp[p], ex[p]);
			loc[p] = ~loc[p];
			if (i % 4 < 2) begin
				rd_reg(p ? 9'h0D8 : 9'h1D8, {30'h0, 1'b1, |ex[p][8:5]});
				rd_mii(p[0], 5'h06, {15'h0, |ex[p][8:5]});
			end else begin
				rd_mii(p[0], 5'h06, {14'h0, 1'b1, |ex[p][8:5]});
				rd_reg(p ? 9'h0D8 : 9'h1D8, {31'h0, |ex[p][8:5]});
			end
			chk(lp[p][11:10], ex[p][11:10]);
			chk(lp[1 - p][11:10], ex[1 - p][11:10]);
		end
		// Clock enable low must freeze a restart, so port 0 keeps its last result
		ce = 1'b0;
		an[0] = 1'b1;
		repeat (3) @(posedge clk);
		#1 an[0] = 1'b0;
		@(posedge clk);
		#1 ce = 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(lp[0], ex[0]);
		rd_reg(9'h1D8, {31'h0, |ex[0][8:5]});
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
